/* File: hw/sbi_pkg.sv */
// Purpose: Shared constants for the serial buffer and interrupt block.
// Assumes: 16-bit register port addressed by byte.
// Notes:   Offsets of own registers sit in otherwise unused space.
package sbi_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [15:0] SBI_OFS_CTL     = 16'h01C0;
	localparam logic [15:0] SBI_OFS_STAT    = 16'h01C8;
	localparam logic [15:0] SBI_OFS_RXBUF   = 16'h01CC;
	localparam logic [15:0] SBI_OFS_TXBUF   = 16'h01CE;
	localparam logic [15:0] SBI_OFS_IE      = 16'h01EA;
	localparam logic [15:0] SBI_OFS_IFG     = 16'h01EC;
	localparam logic [15:0] SBI_OFS_IV      = 16'h01EE;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SBI_BIT_RX       = 0;
	localparam int SBI_BIT_TX       = 1;
	localparam int SBI_BIT_SEVEN    = 12;
	localparam int SBI_BIT_FE       = 6;
	localparam int SBI_BIT_OE       = 5;

	// ----------------------------------------------------------------
	// Reset and vector values
	// ----------------------------------------------------------------
	localparam logic [15:0] SBI_RST_IFG     = 16'h0002;
	localparam logic [15:0] SBI_RST_ZERO    = 16'h0000;
	localparam logic [15:0] SBI_IV_NONE     = 16'h0000;
	localparam logic [15:0] SBI_IV_RX       = 16'h0002;
	localparam logic [15:0] SBI_IV_TX       = 16'h0004;

	typedef enum logic [1:0] {
		SBI_TX_EMPTY = 2'b00,
		SBI_TX_FULL  = 2'b01
	} sbi_txst_e;

endpackage

/* File: hw/sbi_vector.sv */
// Purpose: Prioritised interrupt vector from flags and enables.
// Assumes: Purely combinational.
// Notes:   Receive wins over transmit.
`timescale 1ns/10ps
module sbi_vector
	import sbi_pkg::*;
(
	input  wire logic [1:0]  flags,
	input  wire logic [1:0]  enables,
	output logic      [15:0] vector
);

	logic [1:0] pend;

	// [RULE16] enabled flags only
	assign pend = flags & enables;

	always_comb begin
		// [RULE11] receive highest
		if (pend[SBI_BIT_RX]) begin
			vector = SBI_IV_RX;
		// [RULE12] transmit lowest
		end else if (pend[SBI_BIT_TX]) begin
			vector = SBI_IV_TX;
		// [RULE10] none pending
		end else begin
			vector = SBI_IV_NONE;
		end
	end

endmodule

/* File: hw/sbi_core.sv */
// Purpose: Receive/transmit data buffers, flags, enables and vector.
// Assumes: Shift register logic outside drives rx_load and tx_take.
// Notes:   Register port answers reads one cycle later.
//
// Summary of operation
// [RULE1] Receive buffer low byte holds last character, upper bits read zero.
// [RULE2] Reading receive buffer clears receive flag and error flags.
// [RULE3] In 7-bit mode receive data is right-aligned, top bit zero.
// [RULE4] Transmit buffer holds written low byte until moved to shifter.
// [RULE5] Writing transmit buffer clears transmit-empty flag.
// [RULE6] In 7-bit mode transmit buffer top bit ignored and zero.
// [RULE7] Transmit-empty flag is bit 1, set when buffer empty, resets set.
// [RULE8] Receive-complete flag is bit 0, set on character arrival, resets clear.
// [RULE9] Enable register: bit 1 transmit, bit 0 receive, reset disabled.
// [RULE10] Vector reads 0000h when nothing enabled is pending.
// [RULE11] Vector reads 0002h for receive, highest priority.
// [RULE12] Vector reads 0004h for transmit only, lowest priority.
// [RULE13] Overrun set when new character overwrites unread one, cleared on read.
// [RULE14] Control bit 12 selects 7-bit characters when one.
// [RULE15] Interrupt asserted while any flag and its enable are set.
// [RULE16] Vector reports only enabled flags, computed combinationally.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module sbi_core
	import sbi_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic        rx_load,
	input  wire logic [7:0]  rx_char,
	input  wire logic        frame_err,
	input  wire logic        tx_take,
	output logic      [7:0]  tx_char,
	output logic             tx_valid,
	output logic             seven_bit_char_select,
	output logic             irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]  rx_buffer_reg;
	logic [7:0]  tx_buffer_reg;
	logic [15:0] ctl_reg;
	logic        rx_complete_flag;
	logic        tx_empty_flag;
	logic        rx_irq_enable;
	logic        tx_irq_enable;
	logic        overrun_flag;
	logic        frame_flag;
	logic        unread_reg;
	logic [15:0] irq_vector_value;
	logic [15:0] rdata_next;
	logic        wr_tx;
	logic        rd_rx;
	logic        wr_ifg;
	logic        wr_ie;
	sbi_txst_e   tx_state;

	assign wr_tx  = wr && (addr == SBI_OFS_TXBUF);
	assign wr_ifg = wr && (addr == SBI_OFS_IFG);
	assign wr_ie  = wr && (addr == SBI_OFS_IE);
	assign rd_rx  = rd && (addr == SBI_OFS_RXBUF);

	// [RULE14] character length select
	assign seven_bit_char_select = ctl_reg[SBI_BIT_SEVEN];

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_reg <= SBI_RST_ZERO;
		end else if (wr && addr == SBI_OFS_CTL) begin
			ctl_reg <= wdata;
		end
	end

	// ----------------------------------------------------------------
	// Receive path
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_buffer_reg <= 8'h00;
		end else if (rx_load) begin
			// [RULE1] [RULE3] store, mask top bit
			rx_buffer_reg <= {rx_char[7] & ~seven_bit_char_select, rx_char[6:0]};
		end
	end

	// A load in the same cycle as a read counts as unread: the set wins.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			unread_reg <= 1'b0;
		end else if (rx_load) begin
			unread_reg <= 1'b1;
		end else if (rd_rx) begin
			unread_reg <= 1'b0;
		end
	end

	// [RULE13] overrun detect
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			overrun_flag <= 1'b0;
		end else if (rx_load && unread_reg && !rd_rx) begin
			overrun_flag <= 1'b1;
		end else if (rd_rx) begin
			overrun_flag <= 1'b0;
		end
	end

	// [RULE2] errors clear on read
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			frame_flag <= 1'b0;
		end else if (frame_err) begin
			frame_flag <= 1'b1;
		end else if (rd_rx) begin
			frame_flag <= 1'b0;
		end
	end

	// [RULE8] [RULE2] receive flag
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_complete_flag <= 1'b0;
		end else if (rx_load) begin
			rx_complete_flag <= 1'b1;
		end else if (rd_rx) begin
			rx_complete_flag <= 1'b0;
		end else if (wr_ifg) begin
			rx_complete_flag <= wdata[SBI_BIT_RX];
		end
	end

	// ----------------------------------------------------------------
	// Transmit path
	// ----------------------------------------------------------------
	// [RULE4] [RULE6] hold byte
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_buffer_reg <= 8'h00;
		end else if (wr_tx) begin
			tx_buffer_reg <= {wdata[7] & ~seven_bit_char_select, wdata[6:0]};
		end
	end

	// Write wins over a move in the same cycle so the new byte is kept.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_state <= SBI_TX_EMPTY;
		end else begin
			case (tx_state)
				SBI_TX_EMPTY: begin
					if (wr_tx) begin
						tx_state <= SBI_TX_FULL;
					end
				end
				SBI_TX_FULL: begin
					if (tx_take && !wr_tx) begin
						tx_state <= SBI_TX_EMPTY;
					end
				end
				default: begin
					tx_state <= SBI_TX_EMPTY;
				end
			endcase
		end
	end

	assign tx_valid = (tx_state == SBI_TX_FULL);
	assign tx_char  = tx_buffer_reg;

	// [RULE7] [RULE5] transmit-empty flag
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_empty_flag <= SBI_RST_IFG[SBI_BIT_TX];
		end else if (tx_take && tx_valid && !wr_tx) begin
			tx_empty_flag <= 1'b1;
		end else if (wr_tx) begin
			tx_empty_flag <= 1'b0;
		end else if (wr_ifg) begin
			tx_empty_flag <= wdata[SBI_BIT_TX];
		end
	end

	// ----------------------------------------------------------------
	// Enables, vector and interrupt
	// ----------------------------------------------------------------
	// [RULE9] enable bits
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_irq_enable <= 1'b0;
			tx_irq_enable <= 1'b0;
		end else if (wr_ie) begin
			rx_irq_enable <= wdata[SBI_BIT_RX];
			tx_irq_enable <= wdata[SBI_BIT_TX];
		end
	end

	sbi_vector i_sbi_vector (
		.flags   ({tx_empty_flag, rx_complete_flag}),
		.enables ({tx_irq_enable, rx_irq_enable}),
		.vector  (irq_vector_value)
	);

	// [RULE15] level interrupt
	assign irq = (rx_complete_flag & rx_irq_enable) | (tx_empty_flag & tx_irq_enable);

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb begin
		rdata_next = 16'h0000;
		case (addr)
			SBI_OFS_CTL:   rdata_next = ctl_reg;
			SBI_OFS_STAT: begin
				rdata_next[SBI_BIT_FE] = frame_flag;
				rdata_next[SBI_BIT_OE] = overrun_flag;
			end
			SBI_OFS_RXBUF: rdata_next = {8'h00, rx_buffer_reg};
			SBI_OFS_TXBUF: rdata_next = {8'h00, tx_buffer_reg};
			SBI_OFS_IE:    rdata_next = {14'h0000, tx_irq_enable, rx_irq_enable};
			SBI_OFS_IFG:   rdata_next = {14'h0000, tx_empty_flag, rx_complete_flag};
			SBI_OFS_IV:    rdata_next = irq_vector_value;
			default:       rdata_next = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			rdata <= rdata_next;
		end else begin
			rdata <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_rx_read_clears;
		@(posedge clk) disable iff (sys_rst)
		(rd_rx && !rx_load) |=> !rx_complete_flag && !overrun_flag;
	endproperty
	a_rx_read_clears: assert property (p_rx_read_clears) else $error("rx read did not clear flags"); // [RULE2]

	property p_rx_seven;
		@(posedge clk) disable iff (sys_rst)
		(rx_load && seven_bit_char_select) |=> rx_buffer_reg[7] == 1'b0;
	endproperty
	a_rx_seven: assert property (p_rx_seven) else $error("rx top bit not cleared"); // [RULE3]

	property p_rx_store;
		@(posedge clk) disable iff (sys_rst)
		rx_load |=> rx_buffer_reg[6:0] == $past(rx_char[6:0]) && rx_complete_flag;
	endproperty
	a_rx_store: assert property (p_rx_store) else $error("rx char not stored"); // [RULE8]

	property p_tx_write;
		@(posedge clk) disable iff (sys_rst)
		wr_tx |=> !tx_empty_flag && tx_valid;
	endproperty
	a_tx_write: assert property (p_tx_write) else $error("tx write did not clear empty"); // [RULE5]

	property p_tx_seven;
		@(posedge clk) disable iff (sys_rst)
		(wr_tx && seven_bit_char_select) |=> tx_char[7] == 1'b0;
	endproperty
	a_tx_seven: assert property (p_tx_seven) else $error("tx top bit kept"); // [RULE6]

	property p_overrun;
		@(posedge clk) disable iff (sys_rst)
		(rx_load && unread_reg && !rd_rx) |=> overrun_flag;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun missed"); // [RULE13]

	property p_vec_prio;
		@(posedge clk) disable iff (sys_rst)
		(rx_complete_flag && rx_irq_enable) |-> irq_vector_value == SBI_IV_RX && irq;
	endproperty
	a_vec_prio: assert property (p_vec_prio) else $error("rx vector wrong"); // [RULE11]

	property p_vec_none;
		@(posedge clk) disable iff (sys_rst)
		!irq |-> irq_vector_value == SBI_IV_NONE;
	endproperty
	a_vec_none: assert property (p_vec_none) else $error("vector not zero"); // [RULE10]

	property p_vec_tx;
		@(posedge clk) disable iff (sys_rst)
		(irq && !(rx_complete_flag && rx_irq_enable)) |-> irq_vector_value == SBI_IV_TX;
	endproperty
	a_vec_tx: assert property (p_vec_tx) else $error("tx vector wrong"); // [RULE12]

	property p_tx_take;
		@(posedge clk) disable iff (sys_rst)
		(tx_take && tx_valid && !wr_tx) |=> tx_empty_flag && !tx_valid;
	endproperty
	a_tx_take: assert property (p_tx_take) else $error("tx move not flagged"); // [RULE7]

	property p_rx_read_data;
		@(posedge clk) disable iff (sys_rst)
		rd_rx |=> rdata == {8'h00, $past(rx_buffer_reg)};
	endproperty
	a_rx_read_data: assert property (p_rx_read_data) else $error("rx buffer read wrong"); // [RULE1]

	property p_frame_clear;
		@(posedge clk) disable iff (sys_rst)
		(rd_rx && !frame_err) |=> !frame_flag;
	endproperty
	a_frame_clear: assert property (p_frame_clear) else $error("frame error not cleared"); // [RULE2]

	property p_tx_hold;
		@(posedge clk) disable iff (sys_rst)
		(tx_valid && !wr_tx) |=> $stable(tx_char);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte changed while held"); // [RULE4]

	property p_ie_write;
		@(posedge clk) disable iff (sys_rst)
		wr_ie |=> rx_irq_enable == $past(wdata[SBI_BIT_RX]) && tx_irq_enable == $past(wdata[SBI_BIT_TX]);
	endproperty
	a_ie_write: assert property (p_ie_write) else $error("enable write lost"); // [RULE9]

	property p_seven_sel;
		@(posedge clk) disable iff (sys_rst)
		(wr && addr == SBI_OFS_CTL) |=> seven_bit_char_select == $past(wdata[SBI_BIT_SEVEN]);
	endproperty
	a_seven_sel: assert property (p_seven_sel) else $error("length select wrong"); // [RULE14]

	property p_irq_tx;
		@(posedge clk) disable iff (sys_rst)
		(tx_empty_flag && tx_irq_enable) |-> irq;
	endproperty
	a_irq_tx: assert property (p_irq_tx) else $error("tx interrupt missing"); // [RULE15]

	property p_vec_masked;
		@(posedge clk) disable iff (sys_rst)
		(!rx_irq_enable && !tx_irq_enable) |-> irq_vector_value == SBI_IV_NONE && !irq;
	endproperty
	a_vec_masked: assert property (p_vec_masked) else $error("masked source reported"); // [RULE16]

endmodule

/* File: test/sbi_shifter_model.sv */
// Purpose: Stand-in for the shift register side of the serial block.
// Assumes: The bench calls its tasks; one request at a time.
// Notes:   Idle data lines are inverted so a stale character never reads as fresh.
`timescale 1ns/10ps
module sbi_shifter_model (
	input  wire logic       clk,
	input  wire logic [7:0] tx_char,
	input  wire logic       tx_valid,
	output logic            rx_load,
	output logic [7:0]      rx_char,
	output logic            frame_err,
	output logic            tx_take,
	output logic [7:0]      taken
);
	initial begin
		rx_load = 1'b0;
		rx_char = 8'h00;
		frame_err = 1'b0;
		tx_take = 1'b0;
		taken = 8'h00;
	end

	task automatic recv(input logic [7:0] c);
		@(posedge clk);
		rx_load <= 1'b1;
		rx_char <= c;
		@(posedge clk);
		rx_load <= 1'b0;
		rx_char <= ~c;
	endtask

	task automatic ferr();
		@(posedge clk);
		frame_err <= 1'b1;
		@(posedge clk);
		frame_err <= 1'b0;
	endtask

	// Waits lag + 1 cycles first so a slow shifter is exercised as well.
	task automatic take(input int lag);
		repeat (lag + 1) @(posedge clk);
		tx_take <= 1'b1;
		@(posedge clk);
		taken <= tx_valid ? tx_char : 8'h00;
		tx_take <= 1'b0;
		@(negedge clk);
	endtask
endmodule

/* File: test/sbi_core_tb.sv */
// Purpose: Self-checking bench for the serial buffer and interrupt block.
// Assumes: Register reads answer one cycle after the strobe.
// Notes:   Expected values come from the package constants and from literal values in the tests.
`timescale 1ns/10ps
module sbi_core_tb;
	import sbi_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        rx_load;
	logic [7:0]  rx_char;
	logic        frame_err;
	logic        tx_take;
	logic [7:0]  tx_char;
	logic        tx_valid;
	logic        seven_sel;
	logic        irq;
	logic [7:0]  taken;
	int          fail_count = 0;
	int          num_checks = 0;
	int          cyc = 0;

	always #12.5 clk = ~clk;

	sbi_core i_sbi_core (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rx_load(rx_load), .rx_char(rx_char), .frame_err(frame_err), .tx_take(tx_take),
		.tx_char(tx_char), .tx_valid(tx_valid), .seven_bit_char_select(seven_sel), .irq(irq));
	sbi_shifter_model i_sbi_shifter_model (.clk(clk), .tx_char(tx_char), .tx_valid(tx_valid),
		.rx_load(rx_load), .rx_char(rx_char), .frame_err(frame_err), .tx_take(tx_take), .taken(taken));

	// ----------------------------------------------------------------
	// Compare and bus tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd_chk(SBI_OFS_IFG, SBI_RST_IFG);
		rd_chk(SBI_OFS_IE, SBI_RST_ZERO);
		rd_chk(SBI_OFS_IV, SBI_IV_NONE);
		rd_chk(SBI_OFS_RXBUF, SBI_RST_ZERO);
		rd_chk(16'h0100, 16'h0000);
		wr_reg(SBI_OFS_IE, 16'hFFFF);
		rd_chk(SBI_OFS_IE, 16'h0003);
		rd_chk(SBI_OFS_IV, SBI_IV_TX);
		wr_reg(SBI_OFS_IE, 16'h0000);
		chk_bit(irq, 1'b0);
		$display("test reset values done");
	endtask

	task automatic t_rx();
		i_sbi_shifter_model.recv(8'hA5);
		rd_chk(SBI_OFS_IFG, 16'h0003);
		rd_chk(SBI_OFS_RXBUF, 16'h00A5);
		rd_chk(SBI_OFS_IFG, 16'h0002);
		i_sbi_shifter_model.recv(8'h11);
		i_sbi_shifter_model.recv(8'h3C);
		i_sbi_shifter_model.ferr();
		rd_chk(SBI_OFS_STAT, 16'h0060);
		rd_chk(SBI_OFS_RXBUF, 16'h003C);
		rd_chk(SBI_OFS_STAT, 16'h0000);
		$display("test receive done");
	endtask

	task automatic t_tx();
		wr_reg(SBI_OFS_TXBUF, 16'h12C3);
		chk({8'h00, tx_char}, 16'h00C3);
		chk_bit(tx_valid, 1'b1);
		rd_chk(SBI_OFS_TXBUF, 16'h00C3);
		rd_chk(SBI_OFS_IFG, 16'h0000);
		i_sbi_shifter_model.take(3);
		chk({8'h00, taken}, 16'h00C3);
		chk_bit(tx_valid, 1'b0);
		rd_chk(SBI_OFS_IFG, 16'h0002);
		wr_reg(SBI_OFS_IFG, 16'h0001);
		rd_chk(SBI_OFS_IFG, 16'h0001);
		$display("test transmit done");
	endtask

	task automatic t_seven();
		wr_reg(SBI_OFS_CTL, 16'h1000);
		chk_bit(seven_sel, 1'b1);
		i_sbi_shifter_model.recv(8'hFF);
		rd_chk(SBI_OFS_RXBUF, 16'h007F);
		wr_reg(SBI_OFS_TXBUF, 16'h00FF);
		chk({8'h00, tx_char}, 16'h007F);
		i_sbi_shifter_model.take(0);
		chk({8'h00, taken}, 16'h007F);
		wr_reg(SBI_OFS_CTL, 16'h0000);
		chk_bit(seven_sel, 1'b0);
		$display("test seven bit done");
	endtask

	task automatic t_irq();
		i_sbi_shifter_model.recv(8'h5A);
		wr_reg(SBI_OFS_IE, 16'h0001);
		chk_bit(irq, 1'b1);
		rd_chk(SBI_OFS_IV, SBI_IV_RX);
		wr_reg(SBI_OFS_IE, 16'h0003);
		rd_chk(SBI_OFS_IV, SBI_IV_RX);
		rd_chk(SBI_OFS_RXBUF, 16'h005A);
		rd_chk(SBI_OFS_IV, SBI_IV_TX);
		chk_bit(irq, 1'b1);
		wr_reg(SBI_OFS_IE, 16'h0001);
		chk_bit(irq, 1'b0);
		rd_chk(SBI_OFS_IV, SBI_IV_NONE);
		$display("test interrupt done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			final_report();
		end
	end

	initial begin
		sys_rst <= 1'b1;
		addr <= 16'h0000;
		wdata <= 16'h0000;
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_rx();
		t_tx();
		t_seven();
		t_irq();
		final_report();
	end
endmodule
